// ---- common/chg_i2c_regs.svh ----
`ifndef CHG_I2C_REGS_SVH
`define CHG_I2C_REGS_SVH

// ****************************************************************
// Bus addressing
// ****************************************************************
`define CHG_DEV_ADDR 7'h6b
`define CHG_HS_CODE 5'h01
`define CHG_REG_ADDR_W 8

// ****************************************************************
// Register bank layout
// ****************************************************************
`define CHG_REG_COUNT 5
`define CHG_RO_INDEX 3'h4
`define CHG_RW_RESET 8'h00
`define CHG_UNIMPL_VALUE 8'hff

// ****************************************************************
// Byte framing
// ****************************************************************
`define CHG_BITS_PER_BYTE 4'h8
`define CHG_BIT_FIRST 4'h1
`define CHG_BIT_ZERO 4'h0

`endif

// ---- common/chg_pkg.sv ----
package chg_pkg;

    // ****************************************************************
    // Serial front end states
    // ****************************************************************
    typedef enum logic [2:0] {
        CHG_IDLE,
        CHG_RX,
        CHG_ACK,
        CHG_TX,
        CHG_TX_ACK,
        CHG_TX_NEXT,
        CHG_WAIT
    } chg_state_t;

    // Meaning of the byte being received
    typedef enum logic [1:0] {
        CHG_KIND_ADDR,
        CHG_KIND_REG,
        CHG_KIND_DATA
    } chg_kind_t;

    // ****************************************************************
    // Whole state of the slave front end
    // ****************************************************************
    typedef struct packed {
        logic scl_meta;
        logic scl_sync;
        logic scl_prev;
        logic sda_meta;
        logic sda_sync;
        logic sda_prev;
        chg_state_t state;
        chg_kind_t kind;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic rw;
        logic high_speed;
        logic sda_oe;
        logic sda_o;
        logic wr_en;
        logic [2:0] wr_addr;
        logic [7:0] wr_data;
        logic selected;
    } chg_slave_t;

endpackage

// ---- hw/chg_regbank.sv ----
`timescale 1ns/10ps
`include "chg_i2c_regs.svh"

module chg_regbank #(
    parameter int NUM_REGS = `CHG_REG_COUNT
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic [2:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    // Read port
    input wire logic [7:0] rd_addr_in,
    output logic [7:0] rd_data_out,
    // Read-only status byte
    input wire logic [7:0] status_in,
    // Stored writable registers, index 0 in the low byte
    output logic [31:0] cfg_out
);

    logic [7:0] regs [0:3];

    // ****************************************************************
    // Storage
    // ****************************************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 4; i++) begin
                regs[i] <= `CHG_RW_RESET;
            end
            rd_data_out <= `CHG_UNIMPL_VALUE;
        end else begin
            // Read-only and unmapped indices never reach storage
            if (wr_en_in && wr_addr_in != `CHG_RO_INDEX && 32'(wr_addr_in) < NUM_REGS) begin // RULE_14
                regs[wr_addr_in[1:0]] <= wr_data_in;
            end
            if (rd_addr_in == 8'(`CHG_RO_INDEX)) begin
                rd_data_out <= status_in;
            end else if (32'(rd_addr_in) < NUM_REGS) begin
                rd_data_out <= regs[rd_addr_in[1:0]];
            end else begin
                rd_data_out <= `CHG_UNIMPL_VALUE; // RULE_13
            end
        end
    end

    assign cfg_out = {regs[3], regs[2], regs[1], regs[0]};

endmodule

// ---- hw/chg_i2c_slave.sv ----
`timescale 1ns/10ps
`include "chg_i2c_regs.svh"

// How it works
// RULE_01 - Master opens with start, slave address, register address, then data byte.
// RULE_02 - Each byte addressed to us is acknowledged with SDA low over ninth clock.
// RULE_03 - Written data lands in its register on the acknowledge clock's falling edge.
// RULE_04 - Further register address and data pairs are accepted without a new start.
// RULE_05 - A stop releases SDA, ends the transaction and waits for a fresh start.
// RULE_06 - First byte after start is the slave address, matched against 1101011.
// RULE_07 - Register address byte: upper five bits zero, low three bits select register.
// RULE_08 - Five 8-bit registers: four read and write, one read only.
// RULE_09 - Master keeps SCL within 100 kHz, 400 kHz, or about 3.4 MHz high speed.
// RULE_10 - Only a matching slave address is acknowledged, SDA low over ninth high.
// RULE_11 - High speed master code 00001xxx is not acknowledged but enters high speed.
// RULE_12 - A stop during high speed operation returns to standard and fast speed.
// RULE_13 - Reads from unimplemented register addresses return FFh.
// RULE_14 - Writes to the read-only or unmapped registers are acknowledged, change nothing.

module chg_i2c_slave (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Serial clock, input only; the device never stretches it
    input wire logic scl_in,
    // Serial data, open drain
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Read-only status byte from the charger core
    input wire logic [7:0] status_in,
    // Configuration registers, index 0 in the low byte
    output logic [31:0] cfg_out,
    // Operating speed indication
    output logic high_speed_operation_out,
    // Transaction in progress with this device
    output logic selected_out
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    // ****************************************************************
    // State and register bank
    // ****************************************************************
    chg_pkg::chg_slave_t st;
    chg_pkg::chg_slave_t next_st;
    logic [7:0] rd_data;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    chg_regbank #(
        .NUM_REGS(`CHG_REG_COUNT)
    ) u_regbank (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .wr_en_in(st.wr_en),
        .wr_addr_in(st.wr_addr),
        .wr_data_in(st.wr_data),
        .rd_addr_in(st.ptr),
        .rd_data_out(rd_data),
        .status_in(status_in),
        .cfg_out(cfg_out) // RULE_08
    );

    // ****************************************************************
    // Bus conditions, from the synchronised copies only
    // ****************************************************************
    // No glitch filter on SCL: a noisy clock line will miscount bits
    assign scl_rise = st.scl_sync && !st.scl_prev;
    assign scl_fall = !st.scl_sync && st.scl_prev;
    assign start_seen = st.scl_sync && st.scl_prev && st.sda_prev && !st.sda_sync;
    assign stop_seen = st.scl_sync && st.scl_prev && !st.sda_prev && st.sda_sync;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        next_st.scl_meta = scl_in;
        next_st.scl_sync = st.scl_meta;
        next_st.scl_prev = st.scl_sync;
        next_st.sda_meta = sda_in;
        next_st.sda_sync = st.sda_meta;
        next_st.sda_prev = st.sda_sync;
        next_st.wr_en = 1'b0;
        next_st.sda_o = 1'b0;
        if (stop_seen) begin
            next_st.state = chg_pkg::CHG_IDLE; // RULE_05
            next_st.sda_oe = 1'b0; // RULE_05
            next_st.selected = 1'b0;
            next_st.high_speed = 1'b0; // RULE_12
        end else if (start_seen) begin
            // Repeated start keeps high speed operation
            next_st.state = chg_pkg::CHG_RX; // RULE_01
            next_st.kind = chg_pkg::CHG_KIND_ADDR; // RULE_06
            next_st.cnt = `CHG_BIT_ZERO;
            next_st.sda_oe = 1'b0;
            next_st.selected = 1'b0;
        end else begin
            case (st.state)
                chg_pkg::CHG_RX: begin
                    if (scl_rise && st.cnt != `CHG_BITS_PER_BYTE) begin
                        next_st.shreg = {st.shreg[6:0], st.sda_sync};
                        next_st.cnt = st.cnt + `CHG_BIT_FIRST;
                    end else if (scl_fall && st.cnt == `CHG_BITS_PER_BYTE) begin
                        next_st.cnt = `CHG_BIT_ZERO;
                        next_st.state = chg_pkg::CHG_ACK;
                        next_st.sda_oe = 1'b1; // RULE_02
                        case (st.kind)
                            chg_pkg::CHG_KIND_ADDR: begin
                                if (st.shreg[7:3] == `CHG_HS_CODE) begin
                                    next_st.high_speed = 1'b1; // RULE_11
                                    next_st.sda_oe = 1'b0; // RULE_11
                                    next_st.state = chg_pkg::CHG_WAIT;
                                end else if (st.shreg[7:1] == `CHG_DEV_ADDR) begin // RULE_06
                                    next_st.rw = st.shreg[0];
                                    next_st.selected = 1'b1;
                                end else begin
                                    next_st.sda_oe = 1'b0; // RULE_10
                                    next_st.state = chg_pkg::CHG_WAIT;
                                end
                            end
                            chg_pkg::CHG_KIND_REG: begin
                                // Nonzero upper bits leave the pointer unmapped
                                next_st.ptr = st.shreg; // RULE_07
                            end
                            default: begin
                                next_st.wr_data = st.shreg;
                            end
                        endcase
                    end
                end
                chg_pkg::CHG_ACK: begin
                    if (scl_fall) begin
                        next_st.sda_oe = 1'b0;
                        next_st.state = chg_pkg::CHG_RX;
                        case (st.kind)
                            chg_pkg::CHG_KIND_ADDR: begin
                                if (st.rw) begin
                                    next_st.state = chg_pkg::CHG_TX;
                                    next_st.shreg = {rd_data[6:0], 1'b0};
                                    next_st.sda_oe = !rd_data[7];
                                    next_st.cnt = `CHG_BIT_FIRST;
                                end else begin
                                    next_st.kind = chg_pkg::CHG_KIND_REG;
                                end
                            end
                            chg_pkg::CHG_KIND_REG: begin
                                next_st.kind = chg_pkg::CHG_KIND_DATA;
                            end
                            default: begin
                                // Commit on the falling edge closing the acknowledge
                                next_st.wr_en = (st.ptr[7:3] == 5'h00); // RULE_03
                                next_st.wr_addr = st.ptr[2:0];
                                next_st.kind = chg_pkg::CHG_KIND_REG; // RULE_04
                            end
                        endcase
                    end
                end
                chg_pkg::CHG_TX: begin
                    if (scl_fall) begin
                        if (st.cnt == `CHG_BITS_PER_BYTE) begin
                            next_st.sda_oe = 1'b0;
                            next_st.cnt = `CHG_BIT_ZERO;
                            next_st.state = chg_pkg::CHG_TX_ACK;
                        end else begin
                            next_st.sda_oe = !st.shreg[7];
                            next_st.shreg = {st.shreg[6:0], 1'b0};
                            next_st.cnt = st.cnt + `CHG_BIT_FIRST;
                        end
                    end
                end
                chg_pkg::CHG_TX_ACK: begin
                    if (scl_rise) begin
                        // A not-acknowledge from the master ends our reply
                        next_st.state = st.sda_sync ? chg_pkg::CHG_WAIT : chg_pkg::CHG_TX_NEXT;
                    end
                end
                chg_pkg::CHG_TX_NEXT: begin
                    if (scl_fall) begin
                        // No auto increment: the same register is sent again
                        next_st.state = chg_pkg::CHG_TX;
                        next_st.shreg = {rd_data[6:0], 1'b0};
                        next_st.sda_oe = !rd_data[7];
                        next_st.cnt = `CHG_BIT_FIRST;
                    end
                end
                default: begin
                    next_st.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.scl_meta <= 1'b1;
            st.scl_sync <= 1'b1;
            st.scl_prev <= 1'b1;
            st.sda_meta <= 1'b1;
            st.sda_sync <= 1'b1;
            st.sda_prev <= 1'b1;
            st.state <= chg_pkg::CHG_IDLE;
            st.kind <= chg_pkg::CHG_KIND_ADDR;
            st.ptr <= `CHG_UNIMPL_VALUE;
        end else begin
            st <= next_st;
        end
    end

    assign sda_out = st.sda_o;
    assign sda_oe_out = st.sda_oe;
    assign high_speed_operation_out = st.high_speed;
    assign selected_out = st.selected;

endmodule

// ---- tb/chg_i2c_slave_chk.sv ----
`timescale 1ns/10ps

// ****************************************************************
// Pin checks
// ****************************************************************
module chg_i2c_slave_chk (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    // Serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    // Register side
    input wire logic [7:0] status_in,
    input wire logic [31:0] cfg_out,
    input wire logic high_speed_operation_out,
    input wire logic selected_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);

    drive_low_a: assert property (sda_out == 1'b0) else $error("sda driven high");
    ack_rise_low_a: assert property ($rose(sda_oe_out) |-> !scl_in)
        else $error("sda pulled while scl high");
    ack_fall_low_a: assert property ($fell(sda_oe_out) |-> !scl_in)
        else $error("sda released while scl high");
    ack_stands_a: assert property (scl_in && sda_oe_out |=> sda_oe_out)
        else $error("ack dropped in high phase");
    stop_release_a: assert property (scl_in && $rose(sda_in)
        |-> ##[1:10] (!selected_out && !sda_oe_out)) else $error("stop not honoured");
    hs_exit_a: assert property (scl_in && $rose(sda_in)
        |-> ##[1:10] !high_speed_operation_out) else $error("high speed kept after stop");
    hs_noack_a: assert property ($rose(high_speed_operation_out) |-> !sda_oe_out)
        else $error("master code acknowledged");
    commit_low_a: assert property (!$stable(cfg_out) |-> !scl_in && selected_out)
        else $error("register changed outside ack fall");

    cover property (!$stable(cfg_out));
    cover property ($rose(high_speed_operation_out));
    cover property (scl_in && $rose(sda_in));
endmodule

bind chg_i2c_slave chg_i2c_slave_chk u_chk (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .status_in(status_in),
    .cfg_out(cfg_out),
    .high_speed_operation_out(high_speed_operation_out),
    .selected_out(selected_out)
);

// ---- tb/chg_i2c_master.sv ----
`timescale 1ns/10ps

// ****************************************************************
// Bus master model, SDA open drain, SCL driven push-pull
// ****************************************************************
module chg_i2c_master #(
    // 130 clocks a bit keeps SCL under 400 kHz
    parameter int HALF = 64
) (
    // Clock
    input wire logic core_clk_in,
    // Serial pins
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_out
);
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end

    task automatic pause(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask

    // SDA moves two clocks after SCL falls, so no false start or stop is seen
    task automatic bit_io(input logic b, output logic r);
        pause(2);
        sda_oe_out = !b;
        pause(HALF);
        scl_out = 1'b1;
        pause(HALF);
        r = sda_in;
        scl_out = 1'b0;
    endtask

    task automatic start_cond();
        pause(2);
        sda_oe_out = 1'b0;
        pause(HALF);
        scl_out = 1'b1;
        pause(HALF);
        sda_oe_out = 1'b1;
        pause(HALF);
        scl_out = 1'b0;
    endtask

    task automatic stop_cond();
        pause(2);
        sda_oe_out = 1'b1;
        pause(HALF);
        scl_out = 1'b1;
        pause(HALF);
        sda_oe_out = 1'b0;
        pause(HALF);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask

    task automatic rd_byte(input logic ack_it, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(!ack_it, r);
    endtask
endmodule

// ---- tb/i2c_slave_register_update_test.sv ----
`timescale 1ns/10ps

module i2c_slave_register_update_test;
    logic core_clk_in;
    logic arst_n_in;
    logic [7:0] status_in;
    logic scl;
    logic m_oe;
    logic d_out;
    logic d_oe;
    logic hs;
    logic sel;
    logic [31:0] cfg;
    logic a;
    logic [7:0] v;
    int num_errors = 0;
    int n_checks = 0;
    // Pull-up unless someone pulls low
    wire sda = d_oe ? d_out : !m_oe;

    chg_i2c_slave DUT (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .scl_in(scl),
        .sda_in(sda),
        .sda_out(d_out),
        .sda_oe_out(d_oe),
        .status_in(status_in),
        .cfg_out(cfg),
        .high_speed_operation_out(hs),
        .selected_out(sel)
    );
    chg_i2c_master m (.core_clk_in(core_clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic open_dev();
        m.start_cond();
        m.wr_byte(8'hd6, a);
        check(a, 1'b1);
    endtask

    task automatic wr_pair(input logic [7:0] r, input logic [7:0] d);
        m.wr_byte(r, a);
        check(a, 1'b1);
        m.wr_byte(d, a);
        check(a, 1'b1);
    endtask

    task automatic rd_reg(input logic [7:0] r, input logic [7:0] exp);
        open_dev();
        m.wr_byte(r, a);
        check(a, 1'b1);
        m.start_cond();
        m.wr_byte(8'hd7, a);
        check(a, 1'b1);
        // Master acknowledge asks for a second byte: the same register again
        m.rd_byte(1'b1, v);
        check(v, exp);
        m.rd_byte(1'b0, v);
        check(v, exp);
        m.stop_cond();
    endtask

    task automatic t_reset();
        check({hs, sel, d_oe}, 3'h0);
        check(cfg, 32'h0000_0000);
        $display("t_reset done");
    endtask

    task automatic t_write();
        open_dev();
        wr_pair(8'h00, 8'ha5);
        wr_pair(8'h03, 8'h3c);
        check(sel, 1'b1);
        m.stop_cond();
        check(cfg, 32'h3c00_00a5);
        check(sel, 1'b0);
        $display("t_write done");
    endtask

    // Upper bits set must not alias onto register 3
    task automatic t_refuse();
        open_dev();
        wr_pair(8'h04, 8'h11);
        wr_pair(8'h07, 8'h22);
        wr_pair(8'h0b, 8'h33);
        m.stop_cond();
        check(cfg, 32'h3c00_00a5);
        $display("t_refuse done");
    endtask

    task automatic t_read();
        status_in = 8'h5a;
        rd_reg(8'h00, 8'ha5);
        rd_reg(8'h03, 8'h3c);
        rd_reg(8'h04, 8'h5a);
        rd_reg(8'h05, 8'hff);
        rd_reg(8'h07, 8'hff);
        $display("t_read done");
    endtask

    task automatic t_foreign();
        m.start_cond();
        m.wr_byte(8'hd4, a);
        check(a, 1'b0);
        m.wr_byte(8'h00, a);
        check({a, sel}, 2'h0);
        m.stop_cond();
        m.wr_byte(8'hd6, a);
        check(a, 1'b0);
        $display("t_foreign done");
    endtask

    task automatic t_hs();
        m.start_cond();
        m.wr_byte(8'h0d, a);
        check(a, 1'b0);
        open_dev();
        check(hs, 1'b1);
        wr_pair(8'h02, 8'h99);
        m.stop_cond();
        check(hs, 1'b0);
        check(cfg, 32'h3c99_00a5);
        $display("t_hs done");
    endtask

    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end

    initial begin
        arst_n_in = 1'b0;
        status_in = 8'h00;
        repeat (16) @(negedge core_clk_in);
        arst_n_in = 1'b1;
        repeat (8) @(negedge core_clk_in);
        t_reset();
        t_write();
        t_refuse();
        t_read();
        t_foreign();
        t_hs();
        close_out();
    end
endmodule
